// ==== src/cgcfg_pkg.sv ====
// Purpose: shared constants and types for the clock generator configuration link
// Assumes: 100 MHz system clock on both ends
// Notes:   register offsets are configuration byte indices on the serial link
package cgcfg_pkg;

    localparam logic [7:0] CGCFG_SLAVE_ADDR_W = 8'hD2;
    localparam logic [7:0] CGCFG_CMD_CODE     = 8'h00;
    localparam int         CGCFG_NUM_CFG      = 6;
    localparam int         CGCFG_MAX_COUNT    = 32;

    localparam logic [2:0] CGCFG_OUTPUT_AND_SPREAD_CTRL  = 3'h0;
    localparam logic [2:0] CGCFG_MEMORY_CLOCK_ENABLES    = 3'h1;
    localparam logic [2:0] CGCFG_HUB_CLOCK_ENABLES       = 3'h2;
    localparam logic [2:0] CGCFG_LOCAL_BUS_CLOCK_ENABLES = 3'h3;
    localparam logic [2:0] CGCFG_VIDEO_CLOCK_SOURCE_CTRL = 3'h4;
    localparam logic [2:0] CGCFG_SPREAD_OVERCLOCK_SELECT = 3'h5;

    // power-up values: all enables on, spread off, no overclock, 48 MHz video source
    localparam logic [7:0] CGCFG_RST_BYTE0 = 8'hB6;
    localparam logic [7:0] CGCFG_RST_BYTE1 = 8'h3F;
    localparam logic [7:0] CGCFG_RST_BYTE2 = 8'hE0;
    localparam logic [7:0] CGCFG_RST_BYTE3 = 8'h7E;
    localparam logic [7:0] CGCFG_RST_BYTE4 = 8'h00;
    localparam logic [7:0] CGCFG_RST_BYTE5 = 8'h00;

    // field positions
    localparam int CGCFG_B0_VIDEO  = 7;
    localparam int CGCFG_B0_HOSTF  = 5;
    localparam int CGCFG_B0_HOST   = 4;
    localparam int CGCFG_B0_SPREAD = 3;
    localparam int CGCFG_B0_PIXEL  = 2;
    localparam int CGCFG_B0_USB    = 1;
    localparam int CGCFG_B2_GFX    = 7;
    localparam int CGCFG_B2_HUB1   = 6;
    localparam int CGCFG_B2_HUB0   = 5;
    localparam int CGCFG_B3_MEM133 = 0;
    localparam int CGCFG_B4_VSRC   = 7;
    localparam int CGCFG_B5_SEL_A  = 5;
    localparam int CGCFG_B5_SEL_B  = 6;

    // host side: serial clock phase length in system cycles (8 cycles, three phases per 240 ns bit)
    localparam int         CGCFG_SCL_PERIOD_NS = 160;
    localparam int         CGCFG_CLK_PERIOD_NS = 10;
    localparam logic [7:0] CGCFG_SCL_HALF      = 8'(CGCFG_SCL_PERIOD_NS / CGCFG_CLK_PERIOD_NS / 2);

    // host command register offsets (AXI4-Lite byte addresses)
    localparam logic [5:0] CGCFG_H_CTRL   = 6'h00;
    localparam logic [5:0] CGCFG_H_STATUS = 6'h04;
    localparam logic [5:0] CGCFG_H_DATA0  = 6'h08;
    localparam logic [5:0] CGCFG_H_DATA1  = 6'h0C;

    typedef enum logic [1:0]
    {
        CGCFG_SPREAD_DOWN = 2'b00,
        CGCFG_SPREAD_OFF  = 2'b01,
        CGCFG_SPREAD_CTR  = 2'b10
    } cgcfg_spread_t;

endpackage

// ==== src/cgcfg_link_if.sv ====
// Purpose: two-wire link between host controller and configuration slave
// Assumes: open-drain lines with pull-ups
// Notes:   wire levels are resolved here from the output enables
`timescale 1ns/100ps
interface cgcfg_link_if;
    logic scl_oe;
    logic sda_host_oe;
    logic sda_dev_oe;
    logic scl;
    logic sda;

    assign scl = ~scl_oe;
    assign sda = ~(sda_host_oe | sda_dev_oe);

    modport host
    (
        output scl_oe,
        output sda_host_oe,
        input  scl,
        input  sda
    );

    modport device
    (
        output sda_dev_oe,
        input  scl,
        input  sda
    );
endinterface

// ==== src/cgcfg_device.sv ====
// Purpose: serial configuration slave of the clock generator, block writes only
// Assumes: link pins are asynchronous and sampled through two flip-flops
// Notes:   clock outputs stand for the enable and mode levels fed to the synthesiser
`timescale 1ns/100ps

// Overview of operation
// - only block writes are accepted
// - bytes load ascending from byte zero
// - respond only to address 11010010
// - host sends command zero, then count
// - count between one and thirty-two
// - count equals following data bytes
// - acknowledge every byte received
// - command and count discarded but counted
// - bits shift in msb first
// - byte0 bit3 switches spreading
// - byte0 bits enable host, video, pixel, usb
// - byte1 bits5..0 enable memory clocks
// - byte2 bits7..5 enable graphics, hub clocks
// - byte3 bits6..1 enable local-bus clocks
// - byte3 bit0 memory 133 mode, default off
// - byte4 bit7 video source, default 48
// - disabled outputs held low
// - host writes zero to reserved bits
// - spreading on: pair picks spread, overclock
// - spreading off: pair picks overclock
// - power-up: no overclock, spread off
// - selection applies to all primary outputs
module cgcfg_device
    import cgcfg_pkg::*;
(
    // system
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic                 ce,
    // link
    cgcfg_link_if.device              link,
    // output enables
    output logic                      video_hub_clock_out_en,
    output logic                      host_clock_free_en,
    output logic                      host_clock_en,
    output logic                      pixel_clock_en,
    output logic                      usb_clock_en,
    output logic [5:0]                memory_clock_outs_en,
    output logic                      graphics_port_66m_clock_en,
    output logic [1:0]                hub_66m_clock_outs_en,
    output logic [6:1]                local_bus_clock_outs_en,
    // modes
    output logic                      memory_133m_mode,
    output logic                      video_hub_src_66m,
    output cgcfg_pkg::cgcfg_spread_t  spread_modulation,
    output logic [4:0]                primary_pll_overclock_pct
);
    import cgcfg_pkg::*;

    typedef enum logic [2:0]
    {
        CGCFG_D_IDLE = 3'b000,
        CGCFG_D_BITS = 3'b001,
        CGCFG_D_ACK  = 3'b010,
        CGCFG_D_SKIP = 3'b011
    } cgcfg_dstate_t;

    typedef struct packed
    {
        logic [1:0]    scl_sync;
        logic [1:0]    sda_sync;
        logic          scl_q;
        logic          sda_q;
        cgcfg_dstate_t st;
        logic [2:0]    bitn;
        logic [7:0]    shreg;
        logic [5:0]    bytes;
        logic          sda_oe;
        logic [7:0][7:0] cfg;
    } cgcfg_dev_t;

    cgcfg_dev_t r;
    cgcfg_dev_t next_r;

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    always_comb
    begin
        scl_rise = r.scl_sync[1] & ~r.scl_q;
        scl_fall = ~r.scl_sync[1] & r.scl_q;
        start_c  = r.scl_sync[1] & r.scl_q & r.sda_q & ~r.sda_sync[1];
        stop_c   = r.scl_sync[1] & r.scl_q & ~r.sda_q & r.sda_sync[1];
        next_r = r;
        next_r.scl_sync = {r.scl_sync[0], link.scl};
        next_r.sda_sync = {r.sda_sync[0], link.sda};
        next_r.scl_q = r.scl_sync[1];
        next_r.sda_q = r.sda_sync[1];
        if (start_c)
        begin
            next_r.st = CGCFG_D_BITS;
            next_r.bitn = 3'd0;
            next_r.bytes = 6'd0;
            next_r.sda_oe = 1'b0;
        end
        else if (stop_c)
        begin
            // partial byte dropped: registers only move on a full byte
            next_r.st = CGCFG_D_IDLE;
            next_r.sda_oe = 1'b0;
        end
        else
        begin
            case (r.st)
                CGCFG_D_BITS:
                begin
                    if (scl_rise)
                    begin
                        next_r.shreg = {r.shreg[6:0], r.sda_sync[1]};
                        next_r.bitn = r.bitn + 3'd1;
                    end
                    if (scl_rise && r.bitn == 3'd7)
                    begin
                        next_r.st = CGCFG_D_ACK;
                    end
                end
                CGCFG_D_ACK:
                begin
                    if (scl_fall && !r.sda_oe)
                    begin
                        if (r.bytes == 6'd0 && r.shreg != CGCFG_SLAVE_ADDR_W)
                        begin
                            next_r.st = CGCFG_D_SKIP;
                        end
                        else
                        begin
                            next_r.sda_oe = 1'b1;
                            // bytes 1 and 2 are command and count: counted, values unused
                            if (r.bytes >= 6'd3 && r.bytes < 6'(3 + CGCFG_NUM_CFG))
                            begin
                                next_r.cfg[3'(r.bytes - 6'd3)] = r.shreg;
                            end
                        end
                    end
                    else if (scl_fall && r.sda_oe)
                    begin
                        next_r.sda_oe = 1'b0;
                        next_r.bitn = 3'd0;
                        next_r.st = (r.bytes < 6'(2 + CGCFG_MAX_COUNT)) ? CGCFG_D_BITS : CGCFG_D_SKIP;
                        next_r.bytes = r.bytes + 6'd1;
                    end
                end
                default:
                begin
                    next_r.sda_oe = 1'b0;
                end
            endcase
        end
        if (!ce)
        begin
            next_r = r;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r <= '0;
            r.scl_sync <= 2'b11;
            r.sda_sync <= 2'b11;
            r.scl_q <= 1'b1;
            r.sda_q <= 1'b1;
            r.cfg[0] <= CGCFG_RST_BYTE0;
            r.cfg[1] <= CGCFG_RST_BYTE1;
            r.cfg[2] <= CGCFG_RST_BYTE2;
            r.cfg[3] <= CGCFG_RST_BYTE3;
            r.cfg[4] <= CGCFG_RST_BYTE4;
            r.cfg[5] <= CGCFG_RST_BYTE5;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign link.sda_dev_oe = r.sda_oe;

    // a low enable means the output is held low by the synthesiser
    assign video_hub_clock_out_en     = r.cfg[0][CGCFG_B0_VIDEO];
    assign host_clock_free_en         = r.cfg[0][CGCFG_B0_HOSTF];
    assign host_clock_en              = r.cfg[0][CGCFG_B0_HOST];
    assign pixel_clock_en             = r.cfg[0][CGCFG_B0_PIXEL];
    assign usb_clock_en               = r.cfg[0][CGCFG_B0_USB];
    assign memory_clock_outs_en       = r.cfg[1][5:0];
    assign graphics_port_66m_clock_en = r.cfg[2][CGCFG_B2_GFX];
    assign hub_66m_clock_outs_en      = {r.cfg[2][CGCFG_B2_HUB1], r.cfg[2][CGCFG_B2_HUB0]};
    assign local_bus_clock_outs_en    = r.cfg[3][6:1];
    assign memory_133m_mode           = r.cfg[3][CGCFG_B3_MEM133];
    assign video_hub_src_66m          = r.cfg[4][CGCFG_B4_VSRC];

    // one selection for all primary pll outputs
    always_comb
    begin
        logic [1:0] sel;
        sel = {r.cfg[5][CGCFG_B5_SEL_A], r.cfg[5][CGCFG_B5_SEL_B]};
        if (r.cfg[0][CGCFG_B0_SPREAD])
        begin
            spread_modulation = sel[0] ? CGCFG_SPREAD_CTR : CGCFG_SPREAD_DOWN;
            primary_pll_overclock_pct = sel[1] ? 5'd5 : 5'd0;
        end
        else
        begin
            spread_modulation = CGCFG_SPREAD_OFF;
            case (sel)
                2'b00:   primary_pll_overclock_pct = 5'd0;
                2'b01:   primary_pll_overclock_pct = 5'd10;
                2'b10:   primary_pll_overclock_pct = 5'd5;
                default: primary_pll_overclock_pct = 5'd15;
            endcase
        end
    end
endmodule

// ==== src/cgcfg_host.sv ====
// Purpose: host controller issuing block writes to the clock generator
// Assumes: software fills data words, then writes count and go together
// Notes:   the host drives the serial clock from a divider of aclk
`timescale 1ns/100ps
module cgcfg_host
    import cgcfg_pkg::*;
(
    // system
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        ce,
    // axi4-lite write
    input  wire logic [5:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [5:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // link
    cgcfg_link_if.host       link
);
    import cgcfg_pkg::*;

    typedef enum logic [2:0]
    {
        CGCFG_H_IDLE  = 3'b000,
        CGCFG_H_START = 3'b001,
        CGCFG_H_BIT   = 3'b010,
        CGCFG_H_ACK   = 3'b011,
        CGCFG_H_STOP  = 3'b100
    } cgcfg_hstate_t;

    typedef struct packed
    {
        logic [1:0]      sda_sync;
        logic [31:0]     d0;
        logic [31:0]     d1;
        logic [2:0]      count;
        logic            busy;
        logic            nack;
        logic            aw_got;
        logic            w_got;
        logic [5:0]      awaddr;
        logic [31:0]     wdata;
        logic            bvalid;
        logic            rvalid;
        logic [31:0]     rdata;
        cgcfg_hstate_t   st;
        logic [7:0]      tick;
        logic [1:0]      phase;
        logic [2:0]      bitn;
        logic [3:0]      idx;
        logic            scl_oe;
        logic            sda_oe;
    } cgcfg_host_t;

    cgcfg_host_t r;
    cgcfg_host_t next_r;

    // byte idx: 0 address, 1 command, 2 count, 3.. data
    function automatic logic [7:0] tx_byte(input cgcfg_host_t s);
        logic [63:0] d;
        d = {s.d1, s.d0};
        if (s.idx == 4'd0)
            tx_byte = CGCFG_SLAVE_ADDR_W;
        else if (s.idx == 4'd1)
            tx_byte = CGCFG_CMD_CODE;
        else if (s.idx == 4'd2)
            tx_byte = {5'd0, s.count};
        else
            tx_byte = d[8 * (s.idx - 4'd3) +: 8];
    endfunction

    always_comb
    begin
        logic [7:0] b;
        logic       tk;
        b = tx_byte(r);
        tk = (r.tick == CGCFG_SCL_HALF - 8'd1);
        next_r = r;
        next_r.sda_sync = {r.sda_sync[0], link.sda};
        if (s_axi_awvalid && !r.aw_got && !r.bvalid)
        begin
            next_r.aw_got = 1'b1;
            next_r.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_got && !r.bvalid)
        begin
            next_r.w_got = 1'b1;
            next_r.wdata = s_axi_wdata;
        end
        if (r.aw_got && r.w_got)
        begin
            next_r.aw_got = 1'b0;
            next_r.w_got = 1'b0;
            next_r.bvalid = 1'b1;
            if (r.awaddr == CGCFG_H_DATA0 && !r.busy)
                next_r.d0 = r.wdata;
            else if (r.awaddr == CGCFG_H_DATA1 && !r.busy)
                next_r.d1 = r.wdata;
            else if (r.awaddr == CGCFG_H_CTRL && !r.busy && r.wdata[0] && r.wdata[3:1] != 3'd0)
            begin
                next_r.count = (r.wdata[3:1] > 3'd6) ? 3'd6 : r.wdata[3:1];
                next_r.busy = 1'b1;
                next_r.nack = 1'b0;
                next_r.st = CGCFG_H_START;
                next_r.tick = 8'd0;
                next_r.phase = 2'd0;
            end
        end
        if (r.bvalid && s_axi_bready)
            next_r.bvalid = 1'b0;
        if (s_axi_arvalid && !r.rvalid)
        begin
            next_r.rvalid = 1'b1;
            if (s_axi_araddr == CGCFG_H_STATUS)
                next_r.rdata = {30'd0, r.nack, r.busy};
            else if (s_axi_araddr == CGCFG_H_DATA0)
                next_r.rdata = r.d0;
            else if (s_axi_araddr == CGCFG_H_DATA1)
                next_r.rdata = r.d1;
            else if (s_axi_araddr == CGCFG_H_CTRL)
                next_r.rdata = {28'd0, r.count, 1'b0};
            else
                next_r.rdata = 32'h0000_0000;
        end
        if (r.rvalid && s_axi_rready)
            next_r.rvalid = 1'b0;
        next_r.tick = tk ? 8'd0 : r.tick + 8'd1;
        case (r.st)
            CGCFG_H_IDLE:
            begin
                next_r.scl_oe = 1'b0;
                next_r.sda_oe = 1'b0;
                next_r.tick = 8'd0;
            end
            CGCFG_H_START:
                if (tk)
                begin
                    next_r.sda_oe = 1'b1;
                    next_r.phase = r.phase + 2'd1;
                    if (r.phase == 2'd1)
                    begin
                        next_r.scl_oe = 1'b1;
                        next_r.st = CGCFG_H_BIT;
                        next_r.idx = 4'd0;
                        next_r.bitn = 3'd7;
                        next_r.phase = 2'd0;
                    end
                end
            CGCFG_H_BIT, CGCFG_H_ACK:
                if (tk)
                begin
                    next_r.phase = r.phase + 2'd1;
                    if (r.phase == 2'd0)
                        next_r.sda_oe = (r.st == CGCFG_H_BIT) ? ~b[r.bitn] : 1'b0;
                    else if (r.phase == 2'd1)
                        next_r.scl_oe = 1'b0;
                    else
                    begin
                        next_r.scl_oe = 1'b1;
                        next_r.phase = 2'd0;
                        if (r.st == CGCFG_H_BIT)
                        begin
                            next_r.bitn = r.bitn - 3'd1;
                            if (r.bitn == 3'd0)
                                next_r.st = CGCFG_H_ACK;
                        end
                        else if (r.sda_sync[1] || r.idx == 4'(2 + r.count))
                        begin
                            next_r.nack = r.sda_sync[1];
                            next_r.st = CGCFG_H_STOP;
                        end
                        else
                        begin
                            next_r.idx = r.idx + 4'd1;
                            next_r.bitn = 3'd7;
                            next_r.st = CGCFG_H_BIT;
                        end
                    end
                end
            default:
                if (tk)
                begin
                    next_r.phase = r.phase + 2'd1;
                    if (r.phase == 2'd0)
                        next_r.sda_oe = 1'b1;
                    else if (r.phase == 2'd1)
                        next_r.scl_oe = 1'b0;
                    else
                    begin
                        next_r.sda_oe = 1'b0;
                        next_r.busy = 1'b0;
                        next_r.phase = 2'd0;
                        next_r.st = CGCFG_H_IDLE;
                    end
                end
        endcase
        if (!ce)
            next_r = r;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            r <= '0;
            r.sda_sync <= 2'b11;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign s_axi_awready = !r.aw_got && !r.bvalid && ce;
    assign s_axi_wready  = !r.w_got && !r.bvalid && ce;
    assign s_axi_bvalid  = r.bvalid;
    assign s_axi_bresp   = 2'b00;
    assign s_axi_arready = !r.rvalid && ce;
    assign s_axi_rvalid  = r.rvalid;
    assign s_axi_rdata   = r.rdata;
    assign s_axi_rresp   = 2'b00;
    assign link.scl_oe      = r.scl_oe;
    assign link.sda_host_oe = r.sda_oe;
endmodule

// ==== bench/cgcfg_props.sv ====
// Purpose: link checks between host controller and configuration slave
// Assumes: one clock domain, link wires sampled on aclk
// Notes:   bit counter restarts at each start condition
`timescale 1ns/100ps
module cgcfg_props
    import cgcfg_pkg::*;
(
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // link
    input wire logic scl_oe,
    input wire logic sda_host_oe,
    input wire logic sda_dev_oe,
    input wire logic scl,
    input wire logic sda
);
    logic       scl_q, sda_q, first;
    logic [3:0] bits;
    logic [7:0] shift;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_stop;
        scl && scl_q && !sda_q && sda;
    endsequence
    sequence s_ack_pulse;
        sda_dev_oe [*8] ##[12:20] !sda_dev_oe;
    endsequence

    // shift stays unreset: it is only looked at after a full address byte
    always_ff @(posedge aclk)
    begin
        scl_q <= !aresetn | scl;
        sda_q <= !aresetn | sda;
        if (!aresetn || (scl && scl_q && sda_q && !sda))
        begin
            bits  <= 4'h0;
            first <= aresetn;
        end
        else if (scl && !scl_q)
        begin
            bits  <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
            first <= first && bits != 4'h8;
            shift <= (bits == 4'h8) ? shift : {shift[6:0], sda};
        end
    end

    chk_link_released: assert property ($rose(aresetn) |-> !scl_oe && !sda_host_oe && !sda_dev_oe)
        else $error("link not released after reset");
    chk_ack_in_ninth: assert property ($rose(sda_dev_oe) |-> !scl && bits == 4'h8)
        else $error("acknowledge not driven in the ninth low phase");
    chk_ack_release_low: assert property ($fell(sda_dev_oe) |-> !scl)
        else $error("acknowledge released while clock high");
    chk_ack_steady_high: assert property (scl && scl_q |-> $stable(sda_dev_oe))
        else $error("slave data moved while clock high");
    chk_ack_one_bit: assert property ($rose(sda_dev_oe) |-> s_ack_pulse)
        else $error("acknowledge not held for one bit time");
    chk_addr_match: assert property ($rose(sda_dev_oe) && first |-> shift == CGCFG_SLAVE_ADDR_W)
        else $error("address byte acknowledged without a match");
    chk_dev_quiet_data: assert property (sda_dev_oe |-> bits == 4'h8 || bits == 4'h0)
        else $error("slave drives data during a write bit");
    chk_scl_idle_stop: assert property (s_stop |-> scl [*8])
        else $error("serial clock moved right after stop");
endmodule

// ==== bench/cgcfg_bench.sv ====
// Purpose: self-checking bench for host and slave joined over the link
// Assumes: ce held high, full-word strobes
// Notes:   expected outputs come from a byte model updated per transfer
`timescale 1ns/100ps
module cgcfg_bench
    import cgcfg_pkg::*;
;
    typedef struct packed
    {
        logic [2:0]    n;
        logic [31:0]   d0;
        logic [31:0]   d1;
        cgcfg_spread_t sp;
        logic [4:0]    pct;
    } cgcfg_row_t;

    logic          aclk, aresetn, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [5:0]    awa, ara;
    logic [31:0]   wd, rdat, rd;
    logic          vid, hf, h, pix, usb, gfx, m133, vsrc;
    logic [5:0]    mem;
    logic [1:0]    hub;
    logic [6:1]    lb;
    logic [4:0]    pct;
    cgcfg_spread_t sp;
    logic [7:0]    cfg [0:5];
    int            err_total, cmp_count, i;
    cgcfg_row_t    rows [0:11];

    cgcfg_link_if link ();

    cgcfg_host cgcfg_host_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(), .s_axi_rvalid(rv), .s_axi_rready(rr), .link(link));
    cgcfg_device cgcfg_device_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .link(link), .video_hub_clock_out_en(vid),
        .host_clock_free_en(hf), .host_clock_en(h), .pixel_clock_en(pix), .usb_clock_en(usb), .memory_clock_outs_en(mem),
        .graphics_port_66m_clock_en(gfx), .hub_66m_clock_outs_en(hub), .local_bus_clock_outs_en(lb),
        .memory_133m_mode(m133), .video_hub_src_66m(vsrc), .spread_modulation(sp), .primary_pll_overclock_pct(pct));
    cgcfg_props cgcfg_props_i (.aclk(aclk), .aresetn(aresetn), .scl_oe(link.scl_oe), .sda_host_oe(link.sda_host_oe),
        .sda_dev_oe(link.sda_dev_oe), .scl(link.scl), .sda(link.sda));

    initial
    begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task give_verdict;
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task check_byte(input string name, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task check_word(input string name, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask

    task timed_out;
        err_total++;
        $display("wrong value handshake expected answer seen none");
        give_verdict();
    endtask

    task axi_write(input logic [5:0] a, input logic [31:0] d);
        int k;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        for (k = 0; k < 64; k++)
        begin
            @(posedge aclk);
            if (awr)
                awv <= 1'b0;
            if (wr)
                wv <= 1'b0;
            if (bv)
                break;
        end
        br <= 1'b0;
        if (k == 64)
            timed_out();
    endtask

    task axi_read(input logic [5:0] a, output logic [31:0] d);
        int k;
        @(posedge aclk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        for (k = 0; k < 64; k++)
        begin
            @(posedge aclk);
            if (arr)
                arv <= 1'b0;
            d = rdat;
            if (rv)
                break;
        end
        rr <= 1'b0;
        if (k == 64)
            timed_out();
    endtask

    task check_outputs(input cgcfg_spread_t e_sp, input logic [4:0] e_pct);
        check_byte("byte0", cfg[0] & 8'hB6, {vid, 1'b0, hf, h, 1'b0, pix, usb, 1'b0});
        check_byte("byte1", cfg[1] & 8'h3F, {2'h0, mem});
        check_byte("byte2", cfg[2] & 8'hE0, {gfx, hub, 5'h00});
        check_byte("byte3", cfg[3] & 8'h7F, {1'b0, lb, m133});
        check_byte("byte4", cfg[4] & 8'h80, {vsrc, 7'h00});
        check_byte("spread", {6'h00, e_sp}, {6'h00, sp});
        check_byte("overclock", {3'h0, e_pct}, {3'h0, pct});
    endtask

    task run_row(input cgcfg_row_t r);
        int k;
        logic [63:0] w;
        axi_write(CGCFG_H_DATA0, r.d0);
        axi_write(CGCFG_H_DATA1, r.d1);
        axi_write(CGCFG_H_CTRL, {28'h0, r.n, 1'b1});
        for (k = 0; k < 1000; k++)
        begin
            axi_read(CGCFG_H_STATUS, rd);
            if (rd[0] === 1'b0)
                break;
        end
        if (k == 1000)
            timed_out();
        check_word("status", 32'h0, rd);
        w = {r.d1, r.d0};
        for (k = 0; k < 6; k++)
            if (k < r.n)
                cfg[k] = w[8*k +: 8];
        check_outputs(r.sp, r.pct);
    endtask

    task do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        cfg = '{CGCFG_RST_BYTE0, CGCFG_RST_BYTE1, CGCFG_RST_BYTE2, CGCFG_RST_BYTE3, CGCFG_RST_BYTE4, CGCFG_RST_BYTE5};
        check_outputs(CGCFG_SPREAD_OFF, 5'h00);
    endtask

    initial
    begin
        {aresetn, awv, wv, br, arv, rr} = 6'h00;
        awa = 6'h00;
        ara = 6'h00;
        wd = 32'h0;
        err_total = 0;
        cmp_count = 0;
        // count zero must be ignored, count seven clips to six
        rows = '{'{3'h1, 32'h00000008, 32'h0, CGCFG_SPREAD_DOWN, 5'h00},
            '{3'h6, 32'h55A01508, 32'h00000080, CGCFG_SPREAD_DOWN, 5'h00},
            '{3'h6, 32'h55A01508, 32'h00004080, CGCFG_SPREAD_CTR, 5'h00},
            '{3'h6, 32'h55A01508, 32'h00002000, CGCFG_SPREAD_DOWN, 5'h05},
            '{3'h6, 32'h55A01508, 32'h00006000, CGCFG_SPREAD_CTR, 5'h05},
            '{3'h6, 32'h2A402AB0, 32'h0, CGCFG_SPREAD_OFF, 5'h00},
            '{3'h6, 32'h2A402AB0, 32'h00004000, CGCFG_SPREAD_OFF, 5'h0A},
            '{3'h6, 32'h2A402AB0, 32'h00002080, CGCFG_SPREAD_OFF, 5'h05},
            '{3'h6, 32'h2A402AB0, 32'h00006000, CGCFG_SPREAD_OFF, 5'h0F},
            '{3'h3, 32'hFFC03F06, 32'h0, CGCFG_SPREAD_OFF, 5'h0F},
            '{3'h0, 32'h0, 32'h0, CGCFG_SPREAD_OFF, 5'h0F},
            '{3'h7, 32'h0, 32'h0, CGCFG_SPREAD_OFF, 5'h00}};
        do_reset();
        for (i = 0; i < 12; i++)
            run_row(rows[i]);
        axi_read(CGCFG_H_CTRL, rd);
        check_word("count", 32'h0000000C, rd);
        axi_read(6'h10, rd);
        check_word("unmapped", 32'h00000000, rd);
        do_reset();
        give_verdict();
    end
endmodule
